// ### hw/ext_bus_ready_wait_control.sv
// External bus cycle engine with ready handshake, configured over AXI4-Lite.
// Assumes ready and read data are sampled on core_clk_in; one request at a time.
// Functional notes
// R1: External ready input may lengthen or end each bus cycle.
// R2: Software selects whether high or low ready level means ready.
// R3: Synchronous ready is sampled directly; module drives it with the reference clock.
// R4: Asynchronous ready passes a synchroniser, costing at least one extra waitstate.
// R5: Asynchronous ready must stay active one reference period plus setup.
// R6: Inactive ready at a sample point inserts one waitstate, then resamples.
// R7: Active ready at a valid sample point ends the running cycle.
// R8: Synchronous and asynchronous ready use different sample points.
// R9: Ready is ignored until the programmed access-phase units have elapsed.
// R10: Module may drop ready after the strobe's trailing rising edge.
// R11: Module must drop ready before the next cycle's first sample point.
// R12: First sample point follows the cycle's programmed phase lengths.
// R13: Read data captured on the edge that raises the read strobe.
// R14: Later address changes cannot corrupt captured read data.
// R15: Each cycle runs setup, command delay, write setup, access, hold per chip select.
// R16: Phase ranges: setup 1-2 plus 0-3, command 0-3, write 0-1, access 1-32, hold 0-3.
// R17: Ready extends only the access phase.
// R18: Strobes and address stay stable during ready waitstates; hold follows.
`include "ebc_params.svh"
module ext_bus_ready_wait_control #(
    parameter int ADDR_W  = 24,
    parameter int DATA_W  = 16,
    parameter int NUM_CS  = 2,
    parameter int TCS_DIV = `TCS_DIV_DEFAULT
) (
    input  wire logic                      core_clk_in,
    input  wire logic                      resetn_in,
    input  wire logic                      axi_awvalid_in,
    output logic                           axi_awready_out,
    input  wire logic [7:0]                axi_awaddr_in,
    input  wire logic                      axi_wvalid_in,
    output logic                           axi_wready_out,
    input  wire logic [31:0]               axi_wdata_in,
    input  wire logic [3:0]                axi_wstrb_in,
    output logic                           axi_bvalid_out,
    input  wire logic                      axi_bready_in,
    output logic [1:0]                     axi_bresp_out,
    input  wire logic                      axi_arvalid_in,
    output logic                           axi_arready_out,
    input  wire logic [7:0]                axi_araddr_in,
    output logic                           axi_rvalid_out,
    input  wire logic                      axi_rready_in,
    output logic [31:0]                    axi_rdata_out,
    output logic [1:0]                     axi_rresp_out,
    input  wire logic                      req_valid_in,
    output logic                           req_ready_out,
    input  wire logic                      req_write_in,
    input  wire logic [$clog2(NUM_CS)-1:0] req_cs_in,
    input  wire logic [ADDR_W-1:0]         req_addr_in,
    input  wire logic [DATA_W-1:0]         req_wdata_in,
    output logic                           done_out,
    output logic [DATA_W-1:0]              rdata_out,
    output logic [ADDR_W-1:0]              addr_out,
    output logic [DATA_W-1:0]              data_out,
    output logic                           data_oe_out,
    input  wire logic [DATA_W-1:0]         data_in,
    output logic [NUM_CS-1:0]              cs_n_out,
    output logic                           ale_out,
    output logic                           rd_n_out,
    output logic                           wr_n_out,
    input  wire logic                      ready_in,
    output logic                           reference_clock_out
);
    localparam int CSW = $clog2(NUM_CS);

    generate
        if (NUM_CS < 2 || NUM_CS > 8 || TCS_DIV < 2 || ADDR_W < 17 || DATA_W > 32) begin : g_bad
            $error("Unsupported parameter set");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    logic tick;
    logic pre_tick;
    logic high_half;
    rdy_if rif ();

    phase_tick #(.DIV(TCS_DIV)) u_tick (
        .clk_in        (core_clk_in),
        .resetn_in     (resetn_in),
        .tick_out      (tick),
        .pre_tick_out  (pre_tick),
        .high_half_out (high_half)
    );

    ready_sampler u_rdy (
        .clk_in    (core_clk_in),
        .resetn_in (resetn_in),
        .rif       (rif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]           ctrl_reg;
    logic [31:0]           tim_reg [NUM_CS];
    logic                  aw_have_reg;
    logic [7:0]            aw_addr_reg;
    logic                  w_have_reg;
    logic [31:0]           w_data_reg;
    logic [3:0]            w_strb_reg;
    ebc_pkg::phase_t       phase_reg;
    ebc_pkg::timing_t      cur_t_reg;
    logic [5:0]            cnt_reg;
    logic                  cur_wr_reg;
    logic [7:0]            wait_cnt_reg;
    logic                  by_rdy_reg;
    logic [ADDR_W-17:0]    last_hi_reg;

    assign rif.pin        = ready_in;
    assign rif.pol_high   = ctrl_reg[`CTRL_RDY_POL_BIT];  // R2
    assign rif.async_mode = ctrl_reg[`CTRL_RDY_ASYNC_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic ebc_pkg::timing_t unpack_tim(input logic [31:0] r);
        ebc_pkg::timing_t t;
        t.ab  = r[`TIM_AB_LSB +: 2];
        t.abx = r[`TIM_ABX_LSB +: 2];
        t.c   = r[`TIM_C_LSB +: 2];
        t.d   = r[`TIM_D_BIT];
        t.e   = r[`TIM_E_LSB +: 5];
        t.f   = r[`TIM_F_LSB +: 2];
        if (t.ab < `AB_MIN) t.ab = `AB_MIN; // R16
        if (t.ab > `AB_MAX) t.ab = `AB_MAX; // R16
        return t;
    endfunction

    // Next non-empty phase after a given one
    function automatic ebc_pkg::phase_t next_ph(input ebc_pkg::phase_t p, input ebc_pkg::timing_t t,
                                                input logic wr);
        ebc_pkg::phase_t n;
        n = ebc_pkg::PH_IDLE;
        unique case (p)
            ebc_pkg::PH_SETUP:  n = (t.c != 2'h0) ? ebc_pkg::PH_CMD
                                  : (t.d && wr) ? ebc_pkg::PH_WSETUP : ebc_pkg::PH_ACCESS; // R15
            ebc_pkg::PH_CMD:    n = (t.d && wr) ? ebc_pkg::PH_WSETUP : ebc_pkg::PH_ACCESS;
            ebc_pkg::PH_WSETUP: n = ebc_pkg::PH_ACCESS;
            ebc_pkg::PH_ACCESS,
            ebc_pkg::PH_RDY:    n = (t.f != 2'h0) ? ebc_pkg::PH_HOLD : ebc_pkg::PH_IDLE;
            ebc_pkg::PH_HOLD,
            ebc_pkg::PH_IDLE:   n = ebc_pkg::PH_IDLE;
        endcase
        return n;
    endfunction

    function automatic logic [5:0] len_m1(input ebc_pkg::phase_t p, input ebc_pkg::timing_t t);
        logic [5:0] l;
        l = 6'h0;
        unique case (p)
            ebc_pkg::PH_CMD:    l = 6'(t.c) - 6'h1;
            ebc_pkg::PH_ACCESS: l = 6'(t.e);                    // R9 R12
            ebc_pkg::PH_HOLD:   l = 6'(t.f) - 6'h1;
            ebc_pkg::PH_SETUP, ebc_pkg::PH_WSETUP,
            ebc_pkg::PH_RDY, ebc_pkg::PH_IDLE: l = 6'h0;
        endcase
        return l;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_have_reg     <= 1'b0;
            aw_addr_reg     <= 8'h00;
            w_have_reg      <= 1'b0;
            w_data_reg      <= 32'h0000_0000;
            w_strb_reg      <= 4'h0;
            axi_awready_out <= 1'b1;
            axi_wready_out  <= 1'b1;
            axi_bvalid_out  <= 1'b0;
            axi_bresp_out   <= `RESP_OKAY;
        end else begin
            if (axi_awvalid_in && axi_awready_out) begin
                aw_have_reg     <= 1'b1;
                aw_addr_reg     <= axi_awaddr_in;
                axi_awready_out <= 1'b0;
            end
            if (axi_wvalid_in && axi_wready_out) begin
                w_have_reg     <= 1'b1;
                w_data_reg     <= axi_wdata_in;
                w_strb_reg     <= axi_wstrb_in;
                axi_wready_out <= 1'b0;
            end
            if (aw_have_reg && w_have_reg && !axi_bvalid_out) begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                axi_bvalid_out <= 1'b1;
                axi_bresp_out  <= (aw_addr_reg == `CTRL_OFS || aw_addr_reg == `STAT_OFS
                                   || aw_addr_reg == `RDATA_OFS
                                   || (aw_addr_reg >= `TIM0_OFS
                                       && aw_addr_reg < 8'(`TIM0_OFS + NUM_CS * `TIM_STRIDE)
                                       && aw_addr_reg[1:0] == 2'h0)) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (axi_bvalid_out && axi_bready_in) begin
                axi_bvalid_out  <= 1'b0;
                axi_awready_out <= 1'b1;
                axi_wready_out  <= 1'b1;
            end
        end
    end

    // Register storage
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (aw_have_reg && w_have_reg && !axi_bvalid_out && aw_addr_reg == `CTRL_OFS) begin
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0007;
        end
    end

    generate
        for (genvar i = 0; i < NUM_CS; i++) begin : g_tim
            always_ff @(posedge core_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    tim_reg[i] <= `TIM_RESET;
                end else if (aw_have_reg && w_have_reg && !axi_bvalid_out
                             && aw_addr_reg == 8'(`TIM0_OFS + i * `TIM_STRIDE)) begin
                    tim_reg[i] <= merge(tim_reg[i], w_data_reg, w_strb_reg) & 32'h0003_1f7f; // R15
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            axi_arready_out <= 1'b1;
            axi_rvalid_out  <= 1'b0;
            axi_rdata_out   <= 32'h0000_0000;
            axi_rresp_out   <= `RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out  <= 1'b1;
            axi_rresp_out   <= `RESP_OKAY;
            axi_rdata_out   <= 32'h0000_0000;
            if (axi_araddr_in == `CTRL_OFS) begin
                axi_rdata_out <= ctrl_reg;
            end else if (axi_araddr_in == `STAT_OFS) begin
                axi_rdata_out <= {16'h0000, wait_cnt_reg, 6'h00, by_rdy_reg,
                                  phase_reg != ebc_pkg::PH_IDLE};
            end else if (axi_araddr_in == `RDATA_OFS) begin
                axi_rdata_out <= 32'(rdata_out);
            end else if (axi_araddr_in >= `TIM0_OFS && axi_araddr_in[1:0] == 2'h0
                         && axi_araddr_in < 8'(`TIM0_OFS + NUM_CS * `TIM_STRIDE)) begin
                axi_rdata_out <= tim_reg[CSW'((axi_araddr_in - `TIM0_OFS) >> 2)];
            end else begin
                axi_rresp_out <= `RESP_SLVERR;
            end
        end else if (axi_rvalid_out && axi_rready_in) begin
            axi_rvalid_out  <= 1'b0;
            axi_arready_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle phase engine
    logic take;
    logic rdy_ok;
    assign take   = req_valid_in && req_ready_out && tick;
    assign rdy_ok = !ctrl_reg[`CTRL_RDY_EN_BIT] || rif.active;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase_reg    <= ebc_pkg::PH_IDLE;
            cur_t_reg    <= '0;
            cnt_reg      <= 6'h00;
            cur_wr_reg   <= 1'b0;
            wait_cnt_reg <= 8'h00;
            by_rdy_reg   <= 1'b0;
            last_hi_reg  <= '0;
        end else if (take) begin
            phase_reg    <= ebc_pkg::PH_SETUP;
            cur_t_reg    <= unpack_tim(tim_reg[req_cs_in]);
            cur_wr_reg   <= req_write_in;
            wait_cnt_reg <= 8'h00;
            by_rdy_reg   <= 1'b0;
            last_hi_reg  <= req_addr_in[ADDR_W-1:16];
            cnt_reg      <= 6'(unpack_tim(tim_reg[req_cs_in]).ab) - 6'h1
                            + ((req_addr_in[ADDR_W-1:16] != last_hi_reg)
                               ? 6'(unpack_tim(tim_reg[req_cs_in]).abx) : 6'h0); // R16
        end else if (tick && phase_reg != ebc_pkg::PH_IDLE) begin
            if (cnt_reg != 6'h00) begin
                cnt_reg <= cnt_reg - 6'h1;                                      // R9
            end else if (phase_reg == ebc_pkg::PH_ACCESS
                         && ctrl_reg[`CTRL_RDY_EN_BIT] && ctrl_reg[`CTRL_RDY_ASYNC_BIT]) begin
                phase_reg  <= ebc_pkg::PH_RDY;                                  // R4 R8
                wait_cnt_reg <= wait_cnt_reg + 8'h01;
            end else if ((phase_reg == ebc_pkg::PH_ACCESS || phase_reg == ebc_pkg::PH_RDY)
                         && !rdy_ok) begin
                phase_reg  <= ebc_pkg::PH_RDY;                                  // R6 R17 R18
                wait_cnt_reg <= wait_cnt_reg + 8'h01;
            end else begin
                if (phase_reg == ebc_pkg::PH_ACCESS || phase_reg == ebc_pkg::PH_RDY) begin
                    by_rdy_reg <= ctrl_reg[`CTRL_RDY_EN_BIT];                   // R1 R7
                end
                phase_reg <= next_ph(phase_reg, cur_t_reg, cur_wr_reg);
                cnt_reg   <= len_m1(next_ph(phase_reg, cur_t_reg, cur_wr_reg), cur_t_reg); // R12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    logic ending;
    assign ending = tick && cnt_reg == 6'h00
                    && (phase_reg == ebc_pkg::PH_ACCESS || phase_reg == ebc_pkg::PH_RDY)
                    && !(phase_reg == ebc_pkg::PH_ACCESS && ctrl_reg[`CTRL_RDY_EN_BIT]
                         && ctrl_reg[`CTRL_RDY_ASYNC_BIT])
                    && rdy_ok;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_out    <= '0;
            data_out    <= '0;
            data_oe_out <= 1'b0;
            cs_n_out    <= '1;
            ale_out     <= 1'b0;
        end else if (take) begin
            addr_out    <= req_addr_in;
            data_out    <= req_wdata_in;
            data_oe_out <= req_write_in;
            cs_n_out    <= ~(NUM_CS'(1) << req_cs_in);
            ale_out     <= 1'b1;
        end else if (tick && phase_reg != ebc_pkg::PH_SETUP
                     && next_ph(phase_reg, cur_t_reg, cur_wr_reg) == ebc_pkg::PH_IDLE
                     && cnt_reg == 6'h00 && phase_reg == ebc_pkg::PH_HOLD) begin
            data_oe_out <= 1'b0;
            cs_n_out    <= '1;
        end else if (ending && cur_t_reg.f == 2'h0) begin
            data_oe_out <= 1'b0;
            cs_n_out    <= '1;
        end else if (tick && phase_reg == ebc_pkg::PH_SETUP && cnt_reg == 6'h00) begin
            ale_out <= 1'b0;
        end
    end

    // Strobes held through waitstates, released when access ends (by ready when ready is enabled)
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end else if (ending) begin
            rd_n_out <= 1'b1;                                                   // R18
            wr_n_out <= 1'b1;
        end else if (tick && cnt_reg == 6'h00 && phase_reg != ebc_pkg::PH_ACCESS
                     && phase_reg != ebc_pkg::PH_RDY
                     && next_ph(phase_reg, cur_t_reg, cur_wr_reg) == ebc_pkg::PH_ACCESS) begin
            rd_n_out <= cur_wr_reg;
            wr_n_out <= !cur_wr_reg;
        end
    end

    // Read data capture and user side
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out           <= '0;
            done_out            <= 1'b0;
            req_ready_out       <= 1'b0;
            reference_clock_out <= 1'b0;
        end else begin
            reference_clock_out <= high_half;
            req_ready_out       <= pre_tick && (phase_reg == ebc_pkg::PH_IDLE) && !req_ready_out;
            if (ending && !cur_wr_reg) begin
                rdata_out <= data_in;                                           // R13 R14
            end
            done_out <= tick && phase_reg != ebc_pkg::PH_IDLE
                        && (ending ? cur_t_reg.f == 2'h0
                                   : phase_reg == ebc_pkg::PH_HOLD && cnt_reg == 6'h00);
        end
    end
endmodule // ext_bus_ready_wait_control

// ### hw/ebc_params.svh
// Offsets, field positions, reset values and timing counts of the ready-controlled bus engine.
// Assumes inclusion by bare name from design files only.
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH

`define CTRL_OFS           8'h00
`define STAT_OFS           8'h04
`define RDATA_OFS          8'h08
`define TIM0_OFS           8'h10
`define TIM_STRIDE         8'h04

`define CTRL_RDY_EN_BIT    0
`define CTRL_RDY_POL_BIT   1
`define CTRL_RDY_ASYNC_BIT 2
`define CTRL_RESET         32'h0000_0002

`define TIM_AB_LSB         0
`define TIM_ABX_LSB        2
`define TIM_C_LSB          4
`define TIM_D_BIT          6
`define TIM_E_LSB          8
`define TIM_F_LSB          16
`define TIM_RESET          32'h0000_0001

`define STAT_BUSY_BIT      0
`define STAT_BY_RDY_BIT    1
`define STAT_WAIT_LSB      8

`define AB_MIN             2'h1
`define AB_MAX             2'h2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define TCS_DIV_DEFAULT    2

`endif

// ### hw/ebc_pkg.sv
// Types shared by the ready-controlled bus engine.
// Assumes nothing of its surroundings.
package ebc_pkg;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_CMD,
        PH_WSETUP,
        PH_ACCESS,
        PH_RDY,
        PH_HOLD
    } phase_t;

    typedef struct packed {
        logic [1:0] ab;
        logic [1:0] abx;
        logic [1:0] c;
        logic       d;
        logic [4:0] e;
        logic [1:0] f;
    } timing_t;

endpackage

// ### hw/rdy_if.sv
// Carrier between the bus engine and its ready sampler.
// Assumes one clock domain.
interface rdy_if;
    logic pin;
    logic pol_high;
    logic async_mode;
    logic active;

    modport sampler (input pin, input pol_high, input async_mode, output active);
    modport ctrl    (output pin, output pol_high, output async_mode, input active);
endinterface

// ### hw/ready_sampler.sv
// Ready input sampler: polarity choice and optional two-stage synchroniser.
// Assumes the ready pin is synchronous to core_clk_in in synchronous mode.
module ready_sampler (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    rdy_if.sampler    rif
);
    logic meta_reg;
    logic sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for asynchronous ready
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= rif.pin;
            sync_reg <= meta_reg; // R4
        end
    end

    // Level compare chooses which value means ready
    assign rif.active = rif.async_mode ? (sync_reg == rif.pol_high) // R2 R4
                                       : (rif.pin == rif.pol_high); // R3
endmodule // ready_sampler

// ### hw/phase_tick.sv
// Phase time unit divider: one-cycle tick at the end of each unit.
// Assumes a free-running clock and DIV of at least two.
module phase_tick #(
    parameter int DIV = 2
) (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    output logic      tick_out,
    output logic      pre_tick_out,
    output logic      high_half_out
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CW'(DIV - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick_out      = (cnt_reg == CW'(DIV - 1));
    assign pre_tick_out  = (cnt_reg == CW'(DIV - 2));
    assign high_half_out = (cnt_reg < CW'(DIV / 2));
endmodule // phase_tick

// ### dv/ebc_ready_chk.sv
// Strobe, capture and cycle-end checks for the bus engine.
// Assumes a bind to the engine top; one clock domain.
module ebc_ready_chk #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int NUM_CS = 2
) (
    input wire logic              core_clk_in, resetn_in, rd_n_out, wr_n_out, ale_out, data_oe_out, done_out,
    input wire logic [NUM_CS-1:0] cs_n_out,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] data_in, rdata_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!resetn_in);
chk_strobe_excl: assert property (rd_n_out || wr_n_out)
    else $error("strobes overlap");
chk_strobe_cs: assert property (!(rd_n_out && wr_n_out) |-> !(&cs_n_out))
    else $error("strobe without select");
chk_setup_idle: assert property (ale_out || data_oe_out |-> rd_n_out)
    else $error("read strobe early");
chk_addr_stable: assert property (!rd_n_out && !$past(rd_n_out) |-> $stable(addr_out))
    else $error("address moved");
chk_rd_capture: assert property ($rose(rd_n_out) |-> rdata_out == $past(data_in))
    else $error("read data not captured");
chk_access_min: assert property ($fell(rd_n_out) |=> !rd_n_out)
    else $error("access too short");
chk_done_pulse: assert property (done_out |=> !done_out)
    else $error("done too long");
chk_done_idle: assert property (done_out |-> rd_n_out && wr_n_out)
    else $error("strobe at done");
endmodule // ebc_ready_chk
bind ext_bus_ready_wait_control ebc_ready_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_CS(NUM_CS)) chk (.*);

// ### dv/ext_mem_model.sv
// Far-side memory: answers strobes with data and a delayed ready.
// Assumes engine strobes sampled on the core clock.
module ext_mem_model (
    input  wire logic        clk_in, rd_n_in, wr_n_in, pol_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic [3:0]  dly_in,
    output logic             ready_out,
    output logic [15:0]      data_out
);
timeunit 1ns;
timeprecision 1ns;
logic [15:0] mem [16];
logic [3:0]  cnt = 4'h0;
initial data_out = 16'h0;
always @(posedge clk_in) begin
    if (rd_n_in && wr_n_in) begin
        cnt <= 4'h0;
        ready_out <= !pol_in;
    end else begin
        cnt <= (cnt == dly_in) ? cnt : cnt + 4'h1;
        ready_out <= pol_in ^ (cnt != dly_in);
    end
    if (!wr_n_in) mem[addr_in[3:0]] <= wdata_in;
    data_out <= rd_n_in ? ~data_out : mem[addr_in[3:0]];
end
endmodule // ext_mem_model

// ### dv/ext_bus_ready_wait_control_test.sv
// Self-checking bench for the ready-controlled bus engine.
// Assumes the far-side memory model and AXI4-Lite register access.
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", s, e, g); end end
module ext_bus_ready_wait_control_test;
timeunit 1ns;
timeprecision 1ns;
localparam int DIV = 2;
logic core_clk_in = 0, resetn_in = 0, axi_awvalid_in = 0, axi_wvalid_in = 0, axi_bready_in = 0, ready_in;
logic axi_arvalid_in = 0, axi_rready_in = 0, req_valid_in = 0, req_write_in = 0, pol = 1, wq = 0;
logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out, req_ready_out;
logic done_out, data_oe_out, ale_out, rd_n_out, wr_n_out, reference_clock_out, req_cs_in = 0;
logic [7:0]  axi_awaddr_in = 0, axi_araddr_in = 0;
logic [3:0]  axi_wstrb_in = 4'hf, dly = 0;
logic [1:0]  axi_bresp_out, axi_rresp_out, cs_n_out;
logic [2:0]  c = 0;
logic [15:0] req_wdata_in = 0, rdata_out, data_out, data_in, sh [16];
logic [23:0] req_addr_in = 0, addr_out;
logic [31:0] axi_wdata_in = 0, axi_rdata_out, rs = 32'h116b4705, t, m;
logic [33:0] e, dq [$];
logic [16:0] l, lq [$];
int failures = 0, comparisons = 0, n = 0;
ext_bus_ready_wait_control #(.TCS_DIV(DIV)) uut (.*);
ext_mem_model mdl (.clk_in(core_clk_in), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .pol_in(pol), .addr_in(addr_out),
    .wdata_in(data_out), .dly_in(dly), .ready_out(ready_in), .data_out(data_in));
always #50 core_clk_in = ~core_clk_in;
function logic [31:0] nx();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
endfunction
function int cyc(input logic [31:0] p, input logic w);
    return DIV * (p[1:0] + p[5:4] + (w & p[6]) + p[12:8] + 1 + p[17:16]) + 1;
endfunction
task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    dq.push_back({r, 32'h0});
    axi_awvalid_in <= 1;
    axi_wvalid_in <= 1;
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    fork
        begin do @(posedge core_clk_in); while (!axi_awready_out); axi_awvalid_in <= 0; end
        begin do @(posedge core_clk_in); while (!axi_wready_out); axi_wvalid_in <= 0; end
    join
    axi_bready_in <= 1;
    do @(posedge core_clk_in); while (!axi_bvalid_out);
    axi_bready_in <= 0;
endtask
task automatic ar(input logic [7:0] a, input logic [33:0] x);
    dq.push_back(x);
    axi_arvalid_in <= 1;
    axi_araddr_in <= a;
    do @(posedge core_clk_in); while (!axi_arready_out);
    axi_arvalid_in <= 0;
    axi_rready_in <= 1;
    do @(posedge core_clk_in); while (!axi_rvalid_out);
    axi_rready_in <= 0;
endtask
task automatic bus(input logic w, input logic [3:0] k, input logic [7:0] win, input int x, input logic mn);
    t = nx();
    lq.push_back({mn | (c[0] & c[2]), 16'(cyc(m, w) + x + (c[0] & c[2] ? 2 : 0))});
    if (w) sh[k] = t[15:0];
    else dq.push_back({18'h0, sh[k]});
    req_valid_in <= 1;
    req_write_in <= w;
    req_cs_in <= t[31];
    req_addr_in <= {win, t[27:16], k};
    req_wdata_in <= t[15:0];
    do @(posedge core_clk_in); while (!req_ready_out);
    req_valid_in <= 0;
    do @(posedge core_clk_in); while (!done_out);
endtask
always @(posedge core_clk_in) begin
    n = (req_valid_in && req_ready_out) ? 0 : n + 1;
    if (req_valid_in && req_ready_out) wq = req_write_in;
    if ((axi_bvalid_out && axi_bready_in) || (axi_rvalid_out && axi_rready_in)) begin
        e = dq.pop_front();
        `CHK("axi", e, {axi_bvalid_out ? axi_bresp_out : axi_rresp_out, axi_bvalid_out ? 32'h0 : axi_rdata_out})
    end
    if (done_out) begin
        l = lq.pop_front();
        `CHK("cycles", 1'b1, n >= l[15:0] && (l[16] || n == l[15:0]))
        e = wq ? 34'h0 : dq.pop_front();
        `CHK("rdata", e, wq ? 34'h0 : {18'h0, rdata_out})
    end
end
task report_and_stop();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
initial begin
    #2000000;
    failures++;
    report_and_stop();
end
initial begin
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1;
    @(posedge core_clk_in);
    ar(8'h00, 34'h2);
    ar(8'h10, 34'h1);
    ar(8'hfc, 34'h2_0000_0000);
    aw(8'hfc, 32'h0, 2'h2);
    $display("test regs done");
    for (int i = 0; i < 10; i++) begin
        t = nx();
        m = (t & 32'h0003_0770) | (t[0] ? 32'h2 : 32'h1);
        if (i == 0) m[12:8] = 5'h1f;
        c = t[31:29];
        pol <= c[1];
        aw(8'h10, m, 2'h0);
        aw(8'h14, m, 2'h0);
        ar(8'h14, {2'h0, m});
        aw(8'h00, {29'h0, c}, 2'h0);
        bus(1'b1, i[3:0], 8'h0, 0, 1'b0);
        bus(1'b0, i[3:0], 8'h0, 0, 1'b0);
    end
    $display("test cycles done");
    c = 3'h3;
    pol <= 1;
    dly <= 4'h9;
    aw(8'h00, 32'h3, 2'h0);
    bus(1'b0, 4'h0, 8'h0, DIV, 1'b1);
    $display("test ready wait done");
    c = 3'h0;
    m = 32'hd;
    aw(8'h00, 32'h0, 2'h0);
    aw(8'h10, m, 2'h0);
    aw(8'h14, m, 2'h0);
    bus(1'b0, 4'h1, 8'h0, 0, 1'b0);
    bus(1'b0, 4'h1, 8'h5, 3 * DIV, 1'b0);
    $display("test window done");
    report_and_stop();
end
endmodule // ext_bus_ready_wait_control_test
